// >>> common/twi_master_pkg.sv
// Purpose: Shared types and constants of the two-wire master bus state block
// Assumes: core clock of 250 MHz
// Notes: Timeout length has no fixed figure; the default below is a plain choice
package twi_master_pkg;

	localparam int CORE_CLK_PERIOD_PS = 4000;
	localparam int TIMEOUT_US = 200;
	localparam int TIMEOUT_CYCLES = (TIMEOUT_US * 1000000 + CORE_CLK_PERIOD_PS - 1) / CORE_CLK_PERIOD_PS;
	localparam int BAUD_W = 8;
	// Low and high phases each take this many cycles plus the baud value
	localparam int SCL_BASE_HALF = 5;
	localparam int ADDR_BITS = 8;
	localparam int ACK_BIT = 8;
	localparam logic PIN_RESET_LEVEL = 1'b1;

	typedef enum logic [1:0] {
		BS_UNKNOWN = 2'b00,
		BS_IDLE = 2'b01,
		BS_OWNER = 2'b10,
		BS_BUSY = 2'b11
	} bus_state_t;

	localparam bus_state_t BUS_STATE_RESET = BS_UNKNOWN;

	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_LOW = 3'b010,
		M_HIGH = 3'b011,
		M_HOLD = 3'b100,
		M_STOP = 3'b101,
		M_RSTART = 3'b110
	} master_state_t;

	typedef struct packed {
		bus_state_t bus_state;
		logic write_flag;
		logic read_flag;
		logic arb_lost;
		logic bus_error;
		logic rx_ack;
	} master_status_t;

endpackage : twi_master_pkg

// >>> rtl/pin_sync.sv
// Purpose: Two-stage synchroniser for one asynchronous pin level
// Assumes: the pin idles at the reset level
// Notes: The first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic pin_in,
	output logic pin_sync_out
);

	logic meta_q;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			meta_q <= RESET_LEVEL;
			pin_sync_out <= RESET_LEVEL;
		end
		else
		begin
			meta_q <= pin_in;
			pin_sync_out <= meta_q;
		end
	end

endmodule : pin_sync

// >>> rtl/twi_master_bus.sv
// Purpose: Two-wire master bus state tracker, SCL generator and address phase
// Assumes: control bits come from logic on core_clk; SCL and SDA are open drain
// Notes: Data packets after the first read byte are outside this block
`timescale 1ns/1ps
module twi_master_bus #(
	parameter int BAUD_W = twi_master_pkg::BAUD_W,
	parameter int TIMEOUT_CYCLES = twi_master_pkg::TIMEOUT_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic master_enable,
	input wire logic timeout_enable,
	input wire logic [BAUD_W-1:0] baud,
	input wire logic addr_wr,
	input wire logic [7:0] addr_byte,
	input wire logic stop_cmd,
	input wire logic bus_state_wr,
	input wire logic flags_clear,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output twi_master_pkg::master_status_t master_status,
	output logic [7:0] rx_data
);

	localparam int CNT_W = BAUD_W + 1;
	localparam int TMO_W = $clog2(TIMEOUT_CYCLES + 1);

	if (BAUD_W < 1 || BAUD_W > 16 || TIMEOUT_CYCLES < 2)
	begin : g_bad_params
		$error("twi_master_bus: unsupported parameter values");
	end

	logic scl_s, sda_s, scl_p, sda_p;
	logic start_det, stop_det, activity;
	logic [TMO_W-1:0] tmo_cnt_q;
	logic tmo_hit;
	twi_master_pkg::bus_state_t bus_state_q;
	twi_master_pkg::master_state_t m_state_q;
	logic [CNT_W-1:0] cnt_q, half;
	logic [3:0] bit_q;
	logic [7:0] shift_q, addr_q, rx_data_q;
	logic req_q, reading_q, samp_q, scl_oe_q, sda_oe_q;
	logic wif_q, rif_q, arb_q, berr_q, received_ack_flag_q;
	logic hi_done, arb_evt, berr_evt, lose_evt;
	logic addr_end, nack_evt, wack_evt, rd_end, flag_clr;

	pin_sync #(.RESET_LEVEL(twi_master_pkg::PIN_RESET_LEVEL)) u_scl_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pin_in(scl_in),
		.pin_sync_out(scl_s)
	);

	pin_sync #(.RESET_LEVEL(twi_master_pkg::PIN_RESET_LEVEL)) u_sda_sync (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.pin_in(sda_in),
		.pin_sync_out(sda_s)
	);

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			scl_p <= twi_master_pkg::PIN_RESET_LEVEL;
			sda_p <= twi_master_pkg::PIN_RESET_LEVEL;
		end
		else
		begin
			scl_p <= scl_s;
			sda_p <= sda_s;
		end
	end

	// No clock gating here: the detectors stay live in every sleep mode
	assign start_det = scl_s && scl_p && sda_p && !sda_s;
	assign stop_det = scl_s && scl_p && !sda_p && sda_s;
	assign activity = (scl_s ^ scl_p) || (sda_s ^ sda_p);

	// Our own clock hold is quiet time too, but a stalled owner cannot time out: BS_OWNER leaves on a Stop, a lost bit or bus error, a state write or disable
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			tmo_cnt_q <= '0;
		else if (activity || !master_enable)
			tmo_cnt_q <= '0;
		else if (tmo_cnt_q != TMO_W'(TIMEOUT_CYCLES))
			tmo_cnt_q <= tmo_cnt_q + 1'b1;
	end

	assign tmo_hit = timeout_enable && !activity && tmo_cnt_q == TMO_W'(TIMEOUT_CYCLES - 1);

	// Counter runs 0..half inclusive, so each phase lasts baud + SCL_BASE_HALF cycles
	assign half = CNT_W'(baud) + CNT_W'(twi_master_pkg::SCL_BASE_HALF - 1);
	// A low seen after high has begun means another master ended the phase early
	assign hi_done = m_state_q == twi_master_pkg::M_HIGH && (cnt_q == half || (cnt_q != '0 && !scl_s));
	// A released SDA read back low during an address byte bit is a lost bit, also while raising a repeated start
	assign arb_evt = (m_state_q == twi_master_pkg::M_HIGH && scl_s && cnt_q == '0 && !reading_q &&
		bit_q < 4'(twi_master_pkg::ACK_BIT) && !sda_oe_q && !sda_s) ||
		(m_state_q == twi_master_pkg::M_RSTART && bit_q == 4'h1 && scl_s && !sda_s);
	assign berr_evt = (m_state_q == twi_master_pkg::M_LOW || m_state_q == twi_master_pkg::M_HIGH) &&
		(start_det || stop_det);
	assign lose_evt = arb_evt || berr_evt;
	assign addr_end = hi_done && !reading_q && bit_q == 4'(twi_master_pkg::ACK_BIT) && !lose_evt;
	assign nack_evt = addr_end && samp_q;
	assign wack_evt = addr_end && !samp_q && !addr_q[0];
	assign rd_end = hi_done && reading_q && bit_q == 4'h7 && !lose_evt;
	assign flag_clr = flags_clear || addr_wr || stop_cmd;

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			bus_state_q <= twi_master_pkg::BUS_STATE_RESET;
		else if (!master_enable)
			bus_state_q <= twi_master_pkg::BS_UNKNOWN;
		else if (bus_state_wr)
			bus_state_q <= twi_master_pkg::BS_IDLE;
		else if (lose_evt)
			bus_state_q <= twi_master_pkg::BS_BUSY;
		else
		begin
			unique case (bus_state_q)
				twi_master_pkg::BS_UNKNOWN:
					if (stop_det || tmo_hit)
						bus_state_q <= twi_master_pkg::BS_IDLE;
				twi_master_pkg::BS_IDLE:
					if (start_det)
						bus_state_q <= (m_state_q == twi_master_pkg::M_START) ?
							twi_master_pkg::BS_OWNER : twi_master_pkg::BS_BUSY;
				twi_master_pkg::BS_BUSY:
					if (stop_det || tmo_hit)
						bus_state_q <= twi_master_pkg::BS_IDLE;
				// Repeated start is not looked at here, so ownership stands through it
				twi_master_pkg::BS_OWNER:
					if (stop_det)
						bus_state_q <= twi_master_pkg::BS_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
			samp_q <= 1'b1;
		else if (m_state_q == twi_master_pkg::M_HIGH && scl_s && cnt_q == '0)
			samp_q <= sda_s;
	end

	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			m_state_q <= twi_master_pkg::M_IDLE;
			cnt_q <= '0;
			bit_q <= '0;
			shift_q <= '0;
			addr_q <= '0;
			req_q <= 1'b0;
			reading_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
			rx_data_q <= '0;
		end
		else if (!master_enable)
		begin
			m_state_q <= twi_master_pkg::M_IDLE;
			req_q <= 1'b0;
			scl_oe_q <= 1'b0;
			sda_oe_q <= 1'b0;
		end
		else
		begin
			if (addr_wr && (m_state_q == twi_master_pkg::M_IDLE || m_state_q == twi_master_pkg::M_HOLD))
				addr_q <= addr_byte;
			if (addr_wr && m_state_q == twi_master_pkg::M_IDLE)
				req_q <= 1'b1;
			if (lose_evt)
			begin
				m_state_q <= twi_master_pkg::M_IDLE;
				scl_oe_q <= 1'b0;
				sda_oe_q <= 1'b0;
			end
			else
			begin
				unique case (m_state_q)
					twi_master_pkg::M_IDLE:
						if (req_q && bus_state_q == twi_master_pkg::BS_IDLE)
						begin
							sda_oe_q <= 1'b1;
							cnt_q <= '0;
							m_state_q <= twi_master_pkg::M_START;
						end
					twi_master_pkg::M_START:
						if (cnt_q == half)
						begin
							scl_oe_q <= 1'b1;
							cnt_q <= '0;
							bit_q <= '0;
							shift_q <= addr_q;
							reading_q <= 1'b0;
							req_q <= 1'b0;
							m_state_q <= twi_master_pkg::M_LOW;
						end
						else
							cnt_q <= cnt_q + 1'b1;
					twi_master_pkg::M_LOW:
					begin
						if (cnt_q == '0)
							sda_oe_q <= !reading_q && bit_q != 4'(twi_master_pkg::ACK_BIT) && !shift_q[7];
						if (cnt_q == half)
						begin
							scl_oe_q <= 1'b0;
							cnt_q <= '0;
							m_state_q <= twi_master_pkg::M_HIGH;
						end
						else
							cnt_q <= cnt_q + 1'b1;
					end
					twi_master_pkg::M_HIGH:
						if (hi_done)
						begin
							cnt_q <= '0;
							scl_oe_q <= 1'b1;
							if (!reading_q)
							begin
								if (bit_q < 4'(twi_master_pkg::ACK_BIT))
								begin
									shift_q <= {shift_q[6:0], 1'b0};
									bit_q <= bit_q + 4'h1;
									m_state_q <= twi_master_pkg::M_LOW;
								end
								else if (samp_q || !addr_q[0])
									m_state_q <= twi_master_pkg::M_HOLD;
								else
								begin
									reading_q <= 1'b1;
									bit_q <= '0;
									m_state_q <= twi_master_pkg::M_LOW;
								end
							end
							else
							begin
								shift_q <= {shift_q[6:0], samp_q};
								if (bit_q == 4'h7)
								begin
									rx_data_q <= {shift_q[6:0], samp_q};
									m_state_q <= twi_master_pkg::M_HOLD;
								end
								else
								begin
									bit_q <= bit_q + 4'h1;
									m_state_q <= twi_master_pkg::M_LOW;
								end
							end
						end
						else if (scl_s)
							cnt_q <= cnt_q + 1'b1;
					twi_master_pkg::M_HOLD:
						if (stop_cmd)
						begin
							scl_oe_q <= 1'b1;
							sda_oe_q <= 1'b1;
							cnt_q <= '0;
							bit_q <= '0;
							m_state_q <= twi_master_pkg::M_STOP;
						end
						else if (addr_wr)
						begin
							scl_oe_q <= 1'b1;
							sda_oe_q <= 1'b0;
							cnt_q <= '0;
							bit_q <= '0;
							m_state_q <= twi_master_pkg::M_RSTART;
						end
						else
							scl_oe_q <= wif_q || rif_q;
					twi_master_pkg::M_STOP, twi_master_pkg::M_RSTART:
						if (bit_q == 4'h0)
						begin
							if (cnt_q == half)
							begin
								scl_oe_q <= 1'b0;
								cnt_q <= '0;
								bit_q <= 4'h1;
							end
							else
								cnt_q <= cnt_q + 1'b1;
						end
						else if (scl_s)
						begin
							if (cnt_q == half)
							begin
								cnt_q <= '0;
								sda_oe_q <= m_state_q == twi_master_pkg::M_RSTART;
								m_state_q <= (m_state_q == twi_master_pkg::M_RSTART) ?
									twi_master_pkg::M_START : twi_master_pkg::M_IDLE;
							end
							else
								cnt_q <= cnt_q + 1'b1;
						end
					default:
						m_state_q <= twi_master_pkg::M_IDLE;
				endcase
			end
		end
	end

	// A flag set in the cycle of its clear stays set
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wif_q <= 1'b0;
			rif_q <= 1'b0;
			arb_q <= 1'b0;
			berr_q <= 1'b0;
			received_ack_flag_q <= 1'b0;
		end
		else if (!master_enable)
		begin
			wif_q <= 1'b0;
			rif_q <= 1'b0;
			arb_q <= 1'b0;
			berr_q <= 1'b0;
			received_ack_flag_q <= 1'b0;
		end
		else
		begin
			if (lose_evt || nack_evt || wack_evt)
				wif_q <= 1'b1;
			else if (flag_clr)
				wif_q <= 1'b0;
			if (rd_end)
				rif_q <= 1'b1;
			else if (flag_clr)
				rif_q <= 1'b0;
			if (lose_evt)
				arb_q <= 1'b1;
			else if (flag_clr)
				arb_q <= 1'b0;
			if (berr_evt)
				berr_q <= 1'b1;
			else if (flag_clr)
				berr_q <= 1'b0;
			if (nack_evt)
				received_ack_flag_q <= 1'b1;
			else if (wack_evt || rd_end)
				received_ack_flag_q <= 1'b0;
		end
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = scl_oe_q;
	assign sda_oe = sda_oe_q;
	assign rx_data = rx_data_q;
	assign master_status = '{bus_state: bus_state_q, write_flag: wif_q, read_flag: rif_q,
		arb_lost: arb_q, bus_error: berr_q, rx_ack: received_ack_flag_q};

	property p_disable_unknown;
		@(posedge core_clk) disable iff (!rst_b) !master_enable |=> bus_state_q == twi_master_pkg::BS_UNKNOWN;
	endproperty
	a_disable_unknown: assert property (p_disable_unknown) else $error("bus state not unknown");

	property p_write_idle;
		@(posedge core_clk) disable iff (!rst_b)
		(master_enable && bus_state_wr) |=> bus_state_q == twi_master_pkg::BS_IDLE;
	endproperty
	a_write_idle: assert property (p_write_idle) else $error("state write did not idle");

	property p_first_stop;
		@(posedge core_clk) disable iff (!rst_b)
		(master_enable && !bus_state_wr && bus_state_q == twi_master_pkg::BS_UNKNOWN && stop_det)
		|=> bus_state_q == twi_master_pkg::BS_IDLE;
	endproperty
	a_first_stop: assert property (p_first_stop) else $error("stop did not leave unknown");

	property p_timeout_idle;
		@(posedge core_clk) disable iff (!rst_b)
		(master_enable && !bus_state_wr && tmo_hit && bus_state_q == twi_master_pkg::BS_BUSY)
		|=> bus_state_q == twi_master_pkg::BS_IDLE;
	endproperty
	a_timeout_idle: assert property (p_timeout_idle) else $error("timeout did not idle");

	property p_known_stays;
		@(posedge core_clk) disable iff (!rst_b)
		(master_enable && bus_state_q != twi_master_pkg::BS_UNKNOWN) |=> bus_state_q != twi_master_pkg::BS_UNKNOWN;
	endproperty
	a_known_stays: assert property (p_known_stays) else $error("known state fell to unknown");

	property p_foreign_start;
		@(posedge core_clk) disable iff (!rst_b)
		(master_enable && !bus_state_wr && bus_state_q == twi_master_pkg::BS_IDLE && start_det &&
		m_state_q != twi_master_pkg::M_START) |=> bus_state_q == twi_master_pkg::BS_BUSY;
	endproperty
	a_foreign_start: assert property (p_foreign_start) else $error("foreign start not busy");

	property p_defer_start;
		@(posedge core_clk) disable iff (!rst_b)
		(m_state_q == twi_master_pkg::M_IDLE && bus_state_q != twi_master_pkg::BS_IDLE)
		|=> m_state_q != twi_master_pkg::M_START;
	endproperty
	a_defer_start: assert property (p_defer_start) else $error("start issued on non idle bus");

	property p_lost_release;
		@(posedge core_clk) disable iff (!rst_b)
		(master_enable && !bus_state_wr && lose_evt) |=> (!scl_oe_q && !sda_oe_q && wif_q && arb_q &&
		bus_state_q == twi_master_pkg::BS_BUSY) [*2];
	endproperty
	a_lost_release: assert property (p_lost_release) else $error("lost arbitration handling wrong");

	property p_bus_error;
		@(posedge core_clk) disable iff (!rst_b) (master_enable && berr_evt) |=> berr_q && arb_q && wif_q;
	endproperty
	a_bus_error: assert property (p_bus_error) else $error("bus error flags wrong");

	property p_nack;
		@(posedge core_clk) disable iff (!rst_b) (master_enable && nack_evt) |=> wif_q && received_ack_flag_q && scl_oe_q;
	endproperty
	a_nack: assert property (p_nack) else $error("address nack handling wrong");

	property p_write_ack;
		@(posedge core_clk) disable iff (!rst_b)
		(master_enable && wack_evt) |=> wif_q && !received_ack_flag_q && scl_oe_q ##1 scl_oe_q;
	endproperty
	a_write_ack: assert property (p_write_ack) else $error("write ack handling wrong");

	property p_read_byte;
		@(posedge core_clk) disable iff (!rst_b)
		(master_enable && rd_end) |=> rif_q && !received_ack_flag_q && m_state_q == twi_master_pkg::M_HOLD;
	endproperty
	a_read_byte: assert property (p_read_byte) else $error("read byte handling wrong");

	property p_hold_low;
		@(posedge core_clk) disable iff (!rst_b)
		(master_enable && m_state_q == twi_master_pkg::M_HOLD && $past(wif_q || rif_q) && (wif_q || rif_q) &&
		!lose_evt) |-> scl_oe_q;
	endproperty
	a_hold_low: assert property (p_hold_low) else $error("scl released while flag set");

endmodule : twi_master_bus

// >>> dv/i2c_bus_partner.sv
// Purpose: Slave on the far side of the two-wire bus, acks its address and returns one read byte
// Assumes: lines are wired-AND with pull-ups, resolved by the bench
// Notes: Can stretch SCL after the ack and can pull SDA low during address bits to force a collision
`timescale 1ns/1ps
module i2c_bus_partner (
	input wire logic scl,
	input wire logic sda,
	input wire logic [6:0] my_addr,
	input wire logic [7:0] tx_byte,
	input wire logic collide,
	input wire logic [15:0] stretch_ns,
	output logic scl_pull,
	output logic sda_pull,
	output logic [7:0] rx_byte
);
	int bit_n = 99;
	logic drv = 1'b0;
	logic rd = 1'b0;
	logic hit = 1'b0;
	// Collision pull drops the moment the bench withdraws it
	assign sda_pull = drv | (collide & (bit_n >= 0) & (bit_n < 8));
	initial scl_pull = 1'b0;
	initial rx_byte = 8'h00;
	always @(negedge sda)
		if (scl)
		begin
			bit_n = -1;
			drv = 1'b0;
		end
	always @(posedge sda)
		if (scl)
			bit_n = 99;
	always @(posedge scl)
		if (bit_n >= 0 && bit_n < 8)
			rx_byte = {rx_byte[6:0], sda};
	always @(negedge scl)
		if (bit_n < 99)
		begin
			bit_n++;
			if (bit_n == 8)
			begin
				hit = (rx_byte[7:1] == my_addr);
				rd = rx_byte[0];
				drv = hit;
			end
			else if (bit_n >= 9 && bit_n <= 16 && hit && rd)
				drv = ~tx_byte[16 - bit_n];
			else
				drv = 1'b0;
			// Slow slave: hold SCL low after the ack
			if (bit_n == 9 && stretch_ns != 16'h0000)
			begin
				scl_pull = 1'b1;
				#(stretch_ns) scl_pull = 1'b0;
			end
		end
endmodule : i2c_bus_partner

// >>> dv/test_i2c_master_bus_state_and_address.sv
// Purpose: Self-checking bench of the two-wire master bus state and address phase
// Assumes: one slave model plus a bench-driven second master with an 80 ns bit time
// Notes: Time-out shortened to 64 cycles; baud kept at or under the fast-plus limit
`timescale 1ns/1ps
module test_i2c_master_bus_state_and_address;
	localparam int TO_CYC = 64;
	localparam int LIM = 9000;
	logic core_clk, rst_b, master_enable, timeout_enable;
	logic addr_wr, stop_cmd, bus_state_wr, flags_clear;
	logic [7:0] baud, addr_byte, rx_data, tx_byte, p_rx, a;
	logic scl_out, scl_oe, sda_out, sda_oe, p_scl, p_sda, tb_scl, tb_sda, collide;
	logic [6:0] my_addr;
	logic [15:0] stretch;
	twi_master_pkg::master_status_t st;
	int seed = 28686;
	int miscompares = 0;
	int num_checks = 0;
	int n;
	// Open-drain lines with pull-ups: anyone pulling wins
	wire logic scl_w = ~(scl_oe | p_scl | tb_scl);
	wire logic sda_w = ~(sda_oe | p_sda | tb_sda);

	twi_master_bus #(.BAUD_W(8), .TIMEOUT_CYCLES(TO_CYC)) u_dut (
		.core_clk(core_clk), .rst_b(rst_b), .master_enable(master_enable), .timeout_enable(timeout_enable),
		.baud(baud), .addr_wr(addr_wr), .addr_byte(addr_byte), .stop_cmd(stop_cmd),
		.bus_state_wr(bus_state_wr), .flags_clear(flags_clear), .scl_in(scl_w), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .master_status(st),
		.rx_data(rx_data)
	);
	i2c_bus_partner u_partner (
		.scl(scl_w), .sda(sda_w), .my_addr(my_addr), .tx_byte(tx_byte), .collide(collide),
		.stretch_ns(stretch), .scl_pull(p_scl), .sda_pull(p_sda), .rx_byte(p_rx)
	);

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic bs(input logic [7:0] exp);
		check(8'(st.bus_state), exp);
	endtask : bs
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop
	function automatic bit cond(input int w);
		case (w)
			0: return scl_oe === 1'b1;
			1: return scl_oe === 1'b0;
			2: return st.write_flag === 1'b1;
			3: return st.read_flag === 1'b1;
			default: return st.bus_state === twi_master_pkg::BS_IDLE;
		endcase
	endfunction : cond
	task automatic wait_for(input int w, input int lim);
		for (int i = 0; i < lim && !cond(w); i++)
			@(negedge core_clk);
		if (!cond(w))
		begin
			check(8'h00, 8'h01);
			report_and_stop();
		end
	endtask : wait_for
	function automatic logic [7:0] low_len(input logic [7:0] b);
		return b + 8'(twi_master_pkg::SCL_BASE_HALF);
	endfunction : low_len
	task automatic pulse(input logic [3:0] which);
		@(negedge core_clk);
		{addr_wr, stop_cmd, bus_state_wr, flags_clear} = which;
		@(negedge core_clk);
		{addr_wr, stop_cmd, bus_state_wr, flags_clear} = 4'h0;
	endtask : pulse
	task automatic req(input logic [7:0] ab);
		@(negedge core_clk);
		addr_byte = ab;
		pulse(4'h8);
	endtask : req
	task automatic xfer(input logic [7:0] ab, input int w, input bit meas);
		req(ab);
		if (meas)
		begin
			wait_for(0, LIM);
			wait_for(1, LIM);
			wait_for(0, LIM);
			n = 0;
			while (scl_oe === 1'b1 && n < 400)
			begin
				n++;
				@(negedge core_clk);
			end
			check(8'(n), low_len(baud));
		end
		wait_for(w, LIM);
	endtask : xfer
	// Second master: Start leaves SCL held low, Stop releases it
	task automatic foreign_start;
		tb_sda = 1'b1;
		#40 tb_scl = 1'b1;
		#40 tb_sda = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask : foreign_start
	task automatic foreign_stop;
		tb_sda = 1'b1;
		#40 tb_scl = 1'b0;
		#40 tb_sda = 1'b0;
		repeat (4) @(negedge core_clk);
	endtask : foreign_stop

	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end
	initial
	begin
		rst_b = 1'b0;
		master_enable = 1'b1;
		timeout_enable = 1'b0;
		baud = 8'h78;
		{addr_wr, stop_cmd, bus_state_wr, flags_clear} = 4'h0;
		{addr_byte, tx_byte, my_addr, stretch} = '0;
		{tb_scl, tb_sda, collide} = 3'h0;
		repeat (6) @(negedge core_clk);
		rst_b = 1'b1;
		@(negedge core_clk);
		check(8'(st), 8'h00);
		check(8'({scl_oe, sda_oe}), 8'h00);
		foreign_start();
		bs(8'h00);
		foreign_stop();
		bs(8'h01);
		foreign_start();
		bs(8'h03);
		foreign_stop();
		bs(8'h01);
		$display("test bus watch done");
		master_enable = 1'b0;
		repeat (2) @(negedge core_clk);
		master_enable = 1'b1;
		@(negedge core_clk);
		bs(8'h00);
		pulse(4'h2);
		bs(8'h01);
		$display("test enable and force done");
		master_enable = 1'b0;
		@(negedge core_clk);
		master_enable = 1'b1;
		timeout_enable = 1'b1;
		repeat (TO_CYC / 2) @(negedge core_clk);
		bs(8'h00);
		wait_for(4, TO_CYC * 2);
		bs(8'h01);
		foreign_start();
		bs(8'h03);
		wait_for(4, TO_CYC * 2);
		bs(8'h01);
		tb_scl = 1'b0;
		timeout_enable = 1'b0;
		$display("test time-out done");
		for (int k = 0; k < 4; k++)
		begin
			baud = 8'h78 + 8'({$random(seed)} % 16);
			a = (8'($random(seed)) & 8'hfe) | 8'(k % 2);
			my_addr = (k == 2) ? ~a[7:1] : a[7:1];
			tx_byte = 8'($random(seed));
			stretch = (k == 3) ? 16'h012c : 16'h0000;
			xfer(a, (k % 2 == 1) ? 3 : 2, 1'b1);
			check(8'(st.rx_ack), 8'(k == 2));
			check(8'({st.write_flag, st.read_flag}), (k % 2 == 1) ? 8'h01 : 8'h02);
			check(8'(scl_oe), 8'h01);
			check(p_rx, a);
			bs(8'h02);
			if (k % 2 == 1)
			begin
				check(rx_data, tx_byte);
				a = {my_addr, 1'b0};
				xfer(a, 2, 1'b0);
				bs(8'h02);
				check(p_rx, a);
			end
			if (k == 0)
			begin
				pulse(4'h1);
				@(negedge core_clk);
				check(8'(scl_oe), 8'h00);
			end
			pulse(4'h4);
			wait_for(4, LIM);
			bs(8'h01);
			$display("test address case %0d done", k);
		end
		foreign_start();
		req({my_addr, 1'b0});
		repeat (50) @(negedge core_clk);
		check(8'({sda_oe, scl_oe}), 8'h00);
		bs(8'h03);
		foreign_stop();
		wait_for(2, LIM);
		bs(8'h02);
		pulse(4'h4);
		wait_for(4, LIM);
		$display("test deferred start done");
		collide = 1'b1;
		xfer(8'hfe, 2, 1'b0);
		repeat (2) @(negedge core_clk);
		check(8'({st.arb_lost, st.bus_error, scl_oe, sda_oe}), 8'h08);
		bs(8'h03);
		collide = 1'b0;
		wait_for(4, 40);
		bs(8'h01);
		pulse(4'h1);
		check(8'({st.write_flag, st.arb_lost}), 8'h00);
		$display("test collision done");
		// A foreign Start in the middle of our own high phase is a bus error
		req(8'hfe);
		wait_for(0, LIM);
		wait_for(1, LIM);
		repeat (20) @(negedge core_clk);
		tb_sda = 1'b1;
		wait_for(2, 40);
		check(8'({st.arb_lost, st.bus_error, scl_oe, sda_oe}), 8'h0c);
		bs(8'h03);
		tb_sda = 1'b0;
		wait_for(4, 40);
		bs(8'h01);
		$display("test bus error done");
		report_and_stop();
	end
endmodule : test_i2c_master_bus_state_and_address
